// ---- rtl/pmd_cfg.svh ----
// timing, decimation and filter constants for the pdm microphone decimator
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH
`define PMD_CLK_KHZ 40000
`define PMD_OUT_KHZ 16
`define PMD_DEC1 8
`define PMD_DEC2 4
`define PMD_DEC3 6
`define PMD_STAGE1_KHZ 384
`define PMD_STAGE2_KHZ 96
`define PMD_BIT_KHZ (`PMD_OUT_KHZ * `PMD_DEC1 * `PMD_DEC2 * `PMD_DEC3)
`define PMD_HALF_CYC (`PMD_CLK_KHZ / (2 * `PMD_BIT_KHZ))
`define PMD_WORD 32
`define PMD_SCALE_SHIFT 23
`define PMD_DC_HZ 5
`define PMD_DC_K 9
`define PMD_GROUP_DELAY_US 1125
`define PMD_SHIFT_RST 32'h0000_0000
`define PMD_SAT_RST 1'b0
`define PMD_FIFO_DEPTH 8
`endif

// ---- rtl/pmd_pkg.sv ----
// shared types of the pdm microphone decimator
package pmd_pkg;
  typedef logic [31:0] pmd_word_t;
  typedef logic [1:0][31:0] pmd_pair_t;
endpackage : pmd_pkg

// ---- rtl/pmd_top.sv ----
// pdm microphone decimator: sample fifo and two-channel decimation chain
`timescale 1ns/1ps
`include "pmd_cfg.svh"

// ==========================================================
// sample fifo
module pmd_fifo #(
  parameter int W = 64,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } pmd_fifo_st_t;

  pmd_fifo_st_t st_r;
  pmd_fifo_st_t st_nxt;

  // honest flags from the pointer pair
  assign in_ready = !((st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]));
  assign out_valid = (st_r.wp != st_r.rp);
  assign out_data = st_r.mem[st_r.rp[AW-1:0]];

  // push and pop
  always_comb begin
    st_nxt = st_r;
    if (in_valid && in_ready) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : pmd_fifo

// ==========================================================
// decimator top
module pmd_top #(
  parameter int HALF_CYC = `PMD_HALF_CYC,
  parameter int FIFO_DEPTH = `PMD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic mic_clk,
  input wire logic mic_data,
  input wire logic cfg_wr,
  input wire logic [31:0] cfg_wr_shift,
  input wire logic [31:0] cfg_wr_sat,
  input wire logic cfg_rd,
  output logic cfg_rd_valid,
  output logic [31:0] cfg_rd_shift,
  output logic [31:0] cfg_rd_sat,
  output logic pcm_valid,
  input wire logic pcm_ready,
  output logic [31:0] pcm_ch0,
  output logic [31:0] pcm_ch1
);
  typedef struct packed {
    logic [7:0] div;
    logic mclk;
    logic s1;
    logic s2;
    logic [1:0][31:0] acc1;
    logic [1:0][2:0] c1;
    logic [1:0][31:0] acc2;
    logic [1:0][1:0] c2;
    logic [1:0][31:0] acc3;
    logic [1:0][2:0] c3;
    logic [1:0][31:0] xprev;
    logic [1:0][31:0] yprev;
    pmd_pkg::pmd_pair_t pcm;
    logic pend;
    logic [31:0] shift;
    logic sat;
    logic rd_valid;
    logic [31:0] rd_shift;
    logic [31:0] rd_sat;
    logic outv;
    pmd_pkg::pmd_pair_t outd;
  } pmd_st_t;

  pmd_st_t st_r;
  pmd_st_t st_nxt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [63:0] fifo_out_data;

  // shift magnitude, clamped to the word
  function automatic logic [4:0] pmd_mag(input logic [31:0] v);
    logic [31:0] m;
    m = v[31] ? (32'h0 - v) : v;
    pmd_mag = (|m[31:5]) ? 5'h1f : m[4:0];
  endfunction : pmd_mag

  // power-of-two gain with optional clamp
  function automatic logic [31:0] pmd_gain(input logic [31:0] x, input logic [31:0] sh,
                                           input logic sat);
    logic signed [63:0] w;
    logic [4:0] n;
    n = pmd_mag(sh);
    w = $signed({{32{x[31]}}, x}) <<< n;
    if (sh[31]) begin
      pmd_gain = $unsigned($signed(x) >>> n);
    end else if (sat && (w > 64'sh0000_0000_7fff_ffff)) begin
      pmd_gain = 32'h7fff_ffff;
    end else if (sat && (w < -64'sh0000_0000_8000_0000)) begin
      pmd_gain = 32'h8000_0000;
    end else begin
      pmd_gain = w[31:0];
    end
  endfunction : pmd_gain

  assign fifo_pop = fifo_out_valid && (!st_r.outv || pcm_ready);

  // clock divider, decimation chain, command port and output stage
  always_comb begin
    logic edge_ev;
    logic ch;
    logic [31:0] bitv;
    logic [31:0] x;
    logic [31:0] y;
    edge_ev = 1'b0;
    ch = 1'b0;
    bitv = 32'h0;
    x = 32'h0;
    y = 32'h0;
    st_nxt = st_r;
    // two-flop synchroniser on the shared data pin
    st_nxt.s1 = mic_data;
    st_nxt.s2 = st_r.s1;
    // bit clock made by dividing clk
    if (st_r.div == 8'(HALF_CYC - 1)) begin
      st_nxt.div = 8'h0;
      st_nxt.mclk = !st_r.mclk;
      edge_ev = 1'b1;
      ch = st_r.mclk; // left on rising edge, right on falling
    end else begin
      st_nxt.div = st_r.div + 8'h1;
    end
    if (edge_ev) begin
      // pdm bit maps to plus or minus one
      bitv = st_r.s2 ? 32'h0000_0001 : 32'hffff_ffff;
      // boxcar fir by eight
      st_nxt.acc1[ch] = st_r.acc1[ch] + bitv;
      st_nxt.c1[ch] = st_r.c1[ch] + 3'h1;
      if (st_r.c1[ch] == 3'(`PMD_DEC1 - 1)) begin
        st_nxt.c1[ch] = 3'h0;
        st_nxt.acc1[ch] = 32'h0;
        // boxcar fir by four
        st_nxt.acc2[ch] = st_r.acc2[ch] + st_r.acc1[ch] + bitv;
        st_nxt.c2[ch] = st_r.c2[ch] + 2'h1;
        if (st_r.c2[ch] == 2'(`PMD_DEC2 - 1)) begin
          st_nxt.c2[ch] = 2'h0;
          st_nxt.acc2[ch] = 32'h0;
          // boxcar fir by six
          st_nxt.acc3[ch] = st_r.acc3[ch] + st_r.acc2[ch] + st_r.acc1[ch] + bitv;
          st_nxt.c3[ch] = st_r.c3[ch] + 3'h1;
          if (st_r.c3[ch] == 3'(`PMD_DEC3 - 1)) begin
            st_nxt.c3[ch] = 3'h0;
            st_nxt.acc3[ch] = 32'h0;
            x = (st_r.acc3[ch] + st_r.acc2[ch] + st_r.acc1[ch] + bitv) << `PMD_SCALE_SHIFT;
            // single-pole dc blocker, pole 1 - 2^-k
            y = x - st_r.xprev[ch] + st_r.yprev[ch] - ($signed(st_r.yprev[ch]) >>> `PMD_DC_K);
            st_nxt.xprev[ch] = x;
            st_nxt.yprev[ch] = y;
            st_nxt.pcm[ch] = pmd_gain(y, st_r.shift, st_r.sat);
            if (ch) begin
              st_nxt.pend = 1'b1;
            end
          end
        end
      end
    end
    // pair handed to the fifo; a new pair wins over the clear
    if (st_r.pend && fifo_in_ready && !st_nxt.pend) begin
      st_nxt.pend = 1'b0;
    end else if (st_r.pend && fifo_in_ready && !(edge_ev && ch && st_nxt.c3[1] == 3'h0
                                                && st_r.c3[1] == 3'(`PMD_DEC3 - 1))) begin
      st_nxt.pend = 1'b0;
    end
    // configuration write and read
    if (cfg_wr) begin
      st_nxt.shift = cfg_wr_shift;
      st_nxt.sat = (cfg_wr_sat != 32'h0);
    end
    st_nxt.rd_valid = cfg_rd;
    if (cfg_rd) begin
      st_nxt.rd_shift = st_r.shift;
      st_nxt.rd_sat = {31'h0, st_r.sat};
    end
    // registered output stage
    if (pcm_ready) begin
      st_nxt.outv = 1'b0;
    end
    if (fifo_pop) begin
      st_nxt.outv = 1'b1;
      st_nxt.outd = fifo_out_data;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.shift <= `PMD_SHIFT_RST;
      st_r.sat <= `PMD_SAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // sample pairs buffered toward the pipeline
  pmd_fifo #(
    .W(64),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(st_r.pend),
    .in_ready(fifo_in_ready),
    .in_data(st_r.pcm),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  assign mic_clk = st_r.mclk;
  assign cfg_rd_valid = st_r.rd_valid;
  assign cfg_rd_shift = st_r.rd_shift;
  assign cfg_rd_sat = st_r.rd_sat;
  assign pcm_valid = st_r.outv;
  assign pcm_ch0 = st_r.outd[0];
  assign pcm_ch1 = st_r.outd[1];
endmodule : pmd_top

// ---- tb/pmd_checker.sv ----
// port assertions for the pdm microphone decimator
`timescale 1ns/1ps
module pmd_checker #(
  parameter int HALF_CYC = 6
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mic_clk,
  input wire logic cfg_rd,
  input wire logic cfg_rd_valid,
  input wire logic [31:0] cfg_rd_shift,
  input wire logic [31:0] cfg_rd_sat,
  input wire logic pcm_valid,
  input wire logic pcm_ready,
  input wire logic [31:0] pcm_ch0,
  input wire logic [31:0] pcm_ch1
);
  logic prev_r;
  logic seen_r;
  logic [7:0] gap_r;
  wire logic flip = mic_clk != prev_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // bit clock spacing, first toggle after reset skipped
  always_ff @(posedge clk) begin
    prev_r <= mic_clk;
    gap_r <= (!reset_n || flip) ? 8'h00 : gap_r + 8'h01;
    seen_r <= reset_n && (seen_r || flip);
  end
  // ==========================================
  // properties
  a_rd_answer: assert property (cfg_rd |=> cfg_rd_valid)
    else $error("read not answered");
  a_rd_no_spur: assert property (!cfg_rd |=> !cfg_rd_valid)
    else $error("read answer without request");
  a_rd_data_hold: assert property (!cfg_rd |=> $stable(cfg_rd_shift) && $stable(cfg_rd_sat))
    else $error("read data moved");
  a_rd_sat_flag: assert property (cfg_rd_valid |-> cfg_rd_sat[31:1] == 31'h0)
    else $error("saturate flag not boolean");
  a_bit_clk_rate: assert property (flip && seen_r |-> gap_r == HALF_CYC - 1)
    else $error("bit clock toggled early");
  a_bit_clk_gap: assert property (seen_r |-> gap_r < HALF_CYC)
    else $error("bit clock toggled late");
  a_pcm_hold: assert property (pcm_valid && !pcm_ready |=>
    pcm_valid && $stable(pcm_ch0) && $stable(pcm_ch1))
    else $error("pcm pair dropped while stalled");
  a_reset_state: assert property ($rose(reset_n) |-> !mic_clk && !pcm_valid && !cfg_rd_valid
    && cfg_rd_shift == 32'h0 && cfg_rd_sat == 32'h0)
    else $error("state not cleared by reset");
endmodule : pmd_checker

// ---- tb/pmd_mic_model.sv ----
// two pdm microphones sharing one data pin
`timescale 1ns/1ps
module pmd_mic_model #(
  parameter logic LEFT_BIT = 1'b1,
  parameter logic RIGHT_BIT = 1'b0
) (
  input wire logic mic_clk,
  output logic mic_data
);
  // left mic drives while the clock is low, right while it is high
  assign mic_data = mic_clk ? RIGHT_BIT : LEFT_BIT;
endmodule : pmd_mic_model

// ---- tb/tb_top.sv ----
// self-checking bench for the pdm microphone decimator
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic pcm_ready = 1'b1;
  logic [31:0] cfg_wr_shift = 32'h0;
  logic [31:0] cfg_wr_sat = 32'h0;
  logic mic_clk, mic_data, cfg_rd_valid, pcm_valid;
  logic [31:0] cfg_rd_shift, cfg_rd_sat, pcm_ch0, pcm_ch1, p0, p1;
  int n_fail = 0;
  int total_checks = 0;
  int i;
  // ==========================================
  // clock, design and microphones
  always #12.5 clk = ~clk;
  pmd_top #(.HALF_CYC(4), .FIFO_DEPTH(8)) dut (.*);
  pmd_mic_model mics (.*);
  // ==========================================
  // shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task cfg_write(input logic [31:0] sh, input logic [31:0] sat);
    @(posedge clk) cfg_wr <= 1'b1;
    cfg_wr_shift <= sh;
    cfg_wr_sat <= sat;
    @(posedge clk) cfg_wr <= 1'b0;
  endtask : cfg_write
  task cfg_read(input logic [31:0] esh, input logic [31:0] esat);
    @(posedge clk) cfg_rd <= 1'b1;
    @(posedge clk) cfg_rd <= 1'b0;
    #1;
    check({31'h0, cfg_rd_valid}, 32'h1);
    check(cfg_rd_shift, esh);
    check(cfg_rd_sat, esat);
  endtask : cfg_read
  task get_pair;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (pcm_valid !== 1'b1 && i < 4000);
    check({31'h0, pcm_valid}, 32'h1);
    p0 = pcm_ch0;
    p1 = pcm_ch1;
  endtask : get_pair
  // ==========================================
  // scenarios
  task t_reset;
    cfg_read(32'h0, 32'h0);
    get_pair;
    check({31'h0, p0[31]}, 32'h0);
    check({31'h0, p1[31]}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task t_sat;
    cfg_write(32'h0000_0004, 32'h0000_0100);
    cfg_read(32'h0000_0004, 32'h1);
    get_pair;
    get_pair;
    check(p0, 32'h7fff_ffff);
    check(p1, 32'h8000_0000);
    $display("test saturate done");
  endtask : t_sat
  task t_right;
    cfg_write(32'hffff_ffe1, 32'h0);
    cfg_read(32'hffff_ffe1, 32'h0);
    get_pair;
    get_pair;
    check(p0, 32'h0);
    check(p1, 32'hffff_ffff);
    $display("test right shift done");
  endtask : t_right
  task t_fifo;
    @(posedge clk) pcm_ready <= 1'b0;
    repeat (15400) @(posedge clk);
    check({31'h0, pcm_valid}, 32'h1);
    pcm_ready <= 1'b1;
    i = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (pcm_valid === 1'b1) i++;
    end
    check({31'h0, i >= 7}, 32'h1);
    $display("test buffer done");
  endtask : t_fifo
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_sat;
    t_right;
    t_fifo;
    stop_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule : tb_top
bind pmd_top pmd_checker #(.HALF_CYC(HALF_CYC)) chk (.*);
